//--- common/via_consts.svh
// constants for the vectored interrupt acceptance block
// Functional notes
// - A maskable source is eligible only when pending is 1 and mask is 0.
// - Maskable vectoring happens only while the global accept enable is 1.
// - While a high-level handler runs, low-priority requests are refused.
// - Latency 7..32 clocks for high priority, 8..33 clocks for low priority.
// - A request just before a divide may wait until the divide completes.
// - Higher programmed priority wins first; ties go to default ranking.
// - A refused request stays pending and is taken once all conditions hold.
// - Accept: push state word, push PC, clear enable, copy priority, vector.
// - Return from vectored restores the state saved on handler entry.
// - The software trap always raises a software interrupt, never masked.
// - Software interrupt: push state word, PC, clear enable, vector 003EH.
// - Leave a software handler with return from trap, never from vectored.
// - Nesting only after the enable instruction sets accept enable again; a state word write that sets it also allows nesting.
// - Equal or higher priority nests; lower priority stays pending.
// - After a return, one interrupted instruction runs before a pending one.
// - High-level handler: only high nests; otherwise any; software always.
// - In-service level 0 means high handler; 1 means none or low handler.
// - Priority select 0 is the higher level, 1 is the lower level.
// - After a hold instruction, acceptance waits until the next completes.
// - The software trap is no hold, but its cleared enable blocks maskables.
// - Pending flag setting does not depend on the priority select flag.
// - Reset sets the state word to 02H: enable 0, in-service level 1.
`ifndef VIA_CONSTS_SVH
`define VIA_CONSTS_SVH

// ****************************************************
// sizes
// ****************************************************
`define VIA_NSRC 32
`define VIA_IDXW 5
`define VIA_AGEW 6
`define VIA_AGE_MAX 6'h3f

// ****************************************************
// processor state word layout and reset value
// ****************************************************
`define VIA_PSW_IE 7
`define VIA_PSW_ISP 1
`define VIA_PSW_RST 8'h02

// ****************************************************
// vectors
// ****************************************************
`define VIA_TRAP_VEC 16'h003e
`define VIA_VEC_BASE 16'h0004

// ****************************************************
// latency figures in cpu clocks
// ****************************************************
`define VIA_LAT_MIN_HI 7
`define VIA_LAT_MIN_LO 8
`define VIA_LAT_MAX_HI 32
`define VIA_LAT_MAX_LO 33
// cycles from the accept edge to the vector load for a high request
`define VIA_SEQ_CYC 3
// age a request must reach before it may be accepted
`define VIA_AGE_MIN 6'(`VIA_LAT_MIN_HI - `VIA_SEQ_CYC - 1)

`endif

//--- common/via_pkg.sv
// types for the vectored interrupt acceptance block
package via_pkg;

	// entry sequence states
	typedef enum logic [2:0] {
		VIA_IDLE = 3'b000,
		VIA_PUSH_PSW = 3'b001,
		VIA_PUSH_PC = 3'b010,
		VIA_SLOT = 3'b011,
		VIA_LOAD = 3'b100
	} via_state_t;

endpackage

//--- verilog/via_prio.sv
// priority and default-ranking selection among eligible sources
`timescale 1ns/1ps
`include "via_consts.svh"

module via_prio
	import via_pkg::*;
(
	input wire logic [`VIA_NSRC-1:0] i_elig,
	input wire logic [`VIA_NSRC-1:0] i_prio,
	output logic o_found,
	output logic [`VIA_IDXW-1:0] o_idx,
	output logic o_lo
);

	// ****************************************************
	// helpers
	// ****************************************************

	// lowest set index wins the default ranking
	function automatic logic [`VIA_IDXW-1:0] first_idx(
		input logic [`VIA_NSRC-1:0] v);
		logic [`VIA_IDXW-1:0] r;
		r = '0;
		for (int i = `VIA_NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = `VIA_IDXW'(i);
			end
		end
		return r;
	endfunction

	logic [`VIA_NSRC-1:0] hi_set;
	logic [`VIA_NSRC-1:0] lo_set;

	// split by programmed level, 0 is the higher level
	assign hi_set = i_elig & ~i_prio;
	assign lo_set = i_elig & i_prio;

	// high level first, then default ranking inside the level
	always_comb begin
		o_found = |i_elig;
		o_lo = 1'b0;
		o_idx = first_idx(lo_set);
		if (|hi_set) begin
			o_idx = first_idx(hi_set);
		end else if (|lo_set) begin
			o_lo = 1'b1;
		end
	end

endmodule

//--- verilog/via_core.sv
// acceptance, nesting and entry sequencing of vectored interrupts
`timescale 1ns/1ps
`include "via_consts.svh"

module via_core
	import via_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic I_CE,
	input wire logic [`VIA_NSRC-1:0] I_REQ_PEND,
	input wire logic [`VIA_NSRC-1:0] I_REQ_MASK,
	input wire logic [`VIA_NSRC-1:0] I_PRIO_SEL,
	input wire logic I_INSN_END,
	input wire logic I_INSN_HOLD,
	input wire logic I_INSN_DIV,
	input wire logic I_EXEC_EI,
	input wire logic I_EXEC_DI,
	input wire logic I_EXEC_BRK,
	input wire logic I_EXEC_RETURN_FROM_VECTORED,
	input wire logic I_EXEC_RETURN_FROM_TRAP,
	input wire logic I_PSW_WE,
	input wire logic [7:0] I_PSW_WDATA,
	input wire logic [7:0] I_POP_DATA,
	input wire logic [15:0] I_PC,
	output logic [7:0] O_PSW,
	output logic O_MAE,
	output logic O_ISP,
	output logic O_BUSY,
	output logic O_PUSH_PSW,
	output logic O_PUSH_PC,
	output logic [15:0] O_PUSH_DATA,
	output logic O_LOAD_PC,
	output logic [15:0] O_VECTOR,
	output logic O_ACK,
	output logic O_ACK_SW,
	output logic [`VIA_IDXW-1:0] O_ACK_IDX,
	output logic O_SW_ACTIVE
);

	// ****************************************************
	// helpers
	// ****************************************************

	// table address of a maskable source vector
	function automatic logic [15:0] vec_addr(
		input logic [`VIA_IDXW-1:0] idx);
		return `VIA_VEC_BASE + {10'h000, idx, 1'b0};
	endfunction

	// ****************************************************
	// state
	// ****************************************************

	via_state_t state;
	via_state_t next_state;
	logic [7:0] processor_state_word;
	logic [7:0] psw_save;
	logic [15:0] pc_save;
	logic [15:0] vec;
	logic [`VIA_IDXW-1:0] idx_save;
	logic lo_save;
	logic is_sw;
	logic [`VIA_AGEW-1:0] age;
	logic sw_active;

	// ****************************************************
	// eligibility and selection
	// ****************************************************

	logic [`VIA_NSRC-1:0] elig;
	logic [`VIA_NSRC-1:0] allowed;
	logic mae;
	logic in_service_priority_level;
	logic found;
	logic [`VIA_IDXW-1:0] win_idx;
	logic win_lo;

	assign mae = processor_state_word[`VIA_PSW_IE];
	assign in_service_priority_level = processor_state_word[`VIA_PSW_ISP];

	// pending and unmasked; the level flag plays no part here
	assign elig = I_REQ_PEND & ~I_REQ_MASK;

	// a high-level handler shuts out low-level sources
	always_comb begin
		allowed = elig;
		if (!in_service_priority_level) begin
			allowed = elig & ~I_PRIO_SEL;
		end
	end

	// winner by level first, then fixed ranking
	via_prio u_prio (
		.i_elig(allowed),
		.i_prio(I_PRIO_SEL),
		.o_found(found),
		.o_idx(win_idx),
		.o_lo(win_lo)
	);

	// ****************************************************
	// acceptance decision at an instruction boundary
	// ****************************************************

	logic at_edge;
	logic take_sw;
	logic take_mask;

	// only between instructions and while idle
	assign at_edge = I_INSN_END && (state == VIA_IDLE);

	// trap is never masked and beats any maskable source
	assign take_sw = at_edge && I_EXEC_BRK;

	// maskable needs enable, no hold, no divide and the least age
	assign take_mask = at_edge && !I_EXEC_BRK && found
		&& mae
		&& !I_INSN_HOLD
		&& !I_INSN_DIV
		&& (age >= `VIA_AGE_MIN);

	// ****************************************************
	// request age, floor of the acceptance latency
	// ****************************************************

	// counts while an allowed request waits; resets when none is allowed
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			age <= '0;
		end else if (I_CE) begin
			// restart after each entry so a fresh request keeps the floor
			if (!found || take_sw || take_mask) begin
				age <= '0;
			end else if (age != `VIA_AGE_MAX) begin
				age <= age + `VIA_AGEW'(1);
			end
		end
	end

	// ****************************************************
	// entry sequence
	// ****************************************************

	// next state of the entry sequence
	always_comb begin
		next_state = state;
		case (state)
			VIA_IDLE: begin
				if (take_sw || take_mask) begin
					next_state = VIA_PUSH_PSW;
				end
			end
			VIA_PUSH_PSW: begin
				next_state = VIA_PUSH_PC;
			end
			VIA_PUSH_PC: begin
				// low level costs one more clock
				if (lo_save && !is_sw) begin
					next_state = VIA_SLOT;
				end else begin
					next_state = VIA_LOAD;
				end
			end
			VIA_SLOT: begin
				next_state = VIA_LOAD;
			end
			VIA_LOAD: begin
				next_state = VIA_IDLE;
			end
			default: begin
				next_state = VIA_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			state <= VIA_IDLE;
		end else if (I_CE) begin
			state <= next_state;
		end
	end

	// capture of what the entry pushes and where it jumps
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			psw_save <= `VIA_PSW_RST;
			pc_save <= '0;
			vec <= '0;
			idx_save <= '0;
			lo_save <= 1'b0;
			is_sw <= 1'b0;
		end else if (I_CE) begin
			if (take_sw || take_mask) begin
				psw_save <= processor_state_word;
				pc_save <= I_PC;
				is_sw <= take_sw;
				idx_save <= win_idx;
				lo_save <= win_lo;
				if (take_sw) begin
					vec <= `VIA_TRAP_VEC;
				end else begin
					vec <= vec_addr(win_idx);
				end
			end
		end
	end

	// ****************************************************
	// processor state word
	// ****************************************************

	// enable and level change on entry, return and writes
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			processor_state_word <= `VIA_PSW_RST;
		end else if (I_CE) begin
			if (take_sw) begin
				processor_state_word[`VIA_PSW_IE] <= 1'b0;
			end else if (take_mask) begin
				processor_state_word[`VIA_PSW_IE] <= 1'b0;
				processor_state_word[`VIA_PSW_ISP] <= win_lo;
			end else if (I_INSN_END) begin
				if (I_EXEC_RETURN_FROM_VECTORED || I_EXEC_RETURN_FROM_TRAP) begin
					processor_state_word <= I_POP_DATA;
				end else if (I_PSW_WE) begin
					processor_state_word <= I_PSW_WDATA;
				end else if (I_EXEC_EI) begin
					processor_state_word[`VIA_PSW_IE] <= 1'b1;
				end else if (I_EXEC_DI) begin
					processor_state_word[`VIA_PSW_IE] <= 1'b0;
				end
			end
		end
	end

	// software handler marker, cleared by its own return
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			sw_active <= 1'b0;
		end else if (I_CE) begin
			if (take_sw) begin
				sw_active <= 1'b1;
			end else if (I_INSN_END && I_EXEC_RETURN_FROM_TRAP) begin
				sw_active <= 1'b0;
			end
		end
	end

	// ****************************************************
	// sequencer outputs
	// ****************************************************

	// strobes and data toward the sequencer
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_PUSH_PSW <= 1'b0;
			O_PUSH_PC <= 1'b0;
			O_PUSH_DATA <= '0;
			O_LOAD_PC <= 1'b0;
			O_VECTOR <= '0;
		end else if (I_CE) begin
			O_PUSH_PSW <= 1'b0;
			O_PUSH_PC <= 1'b0;
			O_LOAD_PC <= 1'b0;
			case (next_state)
				VIA_PUSH_PSW: begin
					O_PUSH_PSW <= 1'b1;
					O_PUSH_DATA <= {8'h00, processor_state_word};
				end
				VIA_PUSH_PC: begin
					O_PUSH_PC <= 1'b1;
					O_PUSH_DATA <= pc_save;
				end
				VIA_LOAD: begin
					O_LOAD_PC <= 1'b1;
					O_VECTOR <= vec;
				end
				default: begin
					O_PUSH_DATA <= O_PUSH_DATA;
				end
			endcase
		end
	end

	// acknowledge so the source can drop its pending flag
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_ACK <= 1'b0;
			O_ACK_SW <= 1'b0;
			O_ACK_IDX <= '0;
		end else if (I_CE) begin
			O_ACK <= take_mask;
			O_ACK_SW <= take_sw;
			if (take_mask) begin
				O_ACK_IDX <= win_idx;
			end
		end
	end

	// status toward the core
	assign O_PSW = processor_state_word;
	assign O_MAE = mae;
	assign O_ISP = in_service_priority_level;
	assign O_BUSY = (state != VIA_IDLE);
	assign O_SW_ACTIVE = sw_active;

endmodule

//--- verif/via_cpu_model.sv
// sequencer and request source model facing the acceptance core
`timescale 1ns/1ps
`include "via_consts.svh"

module via_cpu_model
	import via_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_busy,
	input wire logic i_ack,
	input wire logic [`VIA_IDXW-1:0] i_ack_idx,
	input wire logic [`VIA_NSRC-1:0] i_raise,
	input wire logic i_go,
	input wire logic [7:0] i_op,
	input wire logic [7:0] i_data,
	output logic [`VIA_NSRC-1:0] o_pend,
	output logic o_end,
	output logic [7:0] o_op,
	output logic o_hold,
	output logic [7:0] o_data
);

// ****************************************************
// request flags and instruction boundaries
// ****************************************************
// flags latch raised requests, whatever their priority, and drop on ack
always_ff @(posedge i_clk) begin
	if (i_srst)
		o_pend <= '0;
	else
		o_pend <= (o_pend | i_raise) & ~(`VIA_NSRC'(i_ack) << i_ack_idx);
end

// one boundary per request, never while the entry sequence runs
always_ff @(posedge i_clk) begin
	o_end <= i_go && !i_busy && !i_srst;
	o_op <= (i_go && !i_busy) ? i_op : 8'h00;
	o_hold <= i_go && !i_busy && |i_op[4:0];
	o_data <= (i_go && !i_busy) ? i_data : ~o_data; // data only valid at a boundary
end

endmodule

//--- verif/via_core_assertions.sv
// assertion checker for the acceptance core
`timescale 1ns/1ps
`include "via_consts.svh"

module via_chk
	import via_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic [`VIA_NSRC-1:0] I_REQ_PEND,
	input wire logic [`VIA_NSRC-1:0] I_REQ_MASK,
	input wire logic [`VIA_NSRC-1:0] I_PRIO_SEL,
	input wire logic I_INSN_END,
	input wire logic I_INSN_HOLD,
	input wire logic I_INSN_DIV,
	input wire logic I_EXEC_BRK,
	input wire logic I_EXEC_RETURN_FROM_VECTORED,
	input wire logic [7:0] I_POP_DATA,
	input wire logic [7:0] O_PSW,
	input wire logic O_MAE,
	input wire logic O_ISP,
	input wire logic O_BUSY,
	input wire logic O_PUSH_PSW,
	input wire logic O_PUSH_PC,
	input wire logic [15:0] O_PUSH_DATA,
	input wire logic O_LOAD_PC,
	input wire logic [15:0] O_VECTOR,
	input wire logic O_ACK,
	input wire logic O_ACK_SW,
	input wire logic [`VIA_IDXW-1:0] O_ACK_IDX
);

// ****************************************************
// properties
// ****************************************************
logic [`VIA_NSRC-1:0] elig_q;
logic [`VIA_NSRC-1:0] hi_q;

// eligible sources as seen at the accept edge
always_ff @(posedge I_CLK) begin
	elig_q <= I_REQ_PEND & ~I_REQ_MASK;
	hi_q <= I_REQ_PEND & ~I_REQ_MASK & ~I_PRIO_SEL;
end

default clocking cb @(posedge I_CLK); endclocking
default disable iff (I_SRST);

property p_entry;
	O_ACK |-> O_PUSH_PSW && !O_MAE && O_PUSH_DATA[`VIA_PSW_IE];
endproperty
a_entry: assert property (p_entry)
	else $error("entry push or enable clear wrong");
property p_hi_seq;
	O_ACK && !O_ISP |=> O_PUSH_PC ##1 O_LOAD_PC;
endproperty
a_hi_seq: assert property (p_hi_seq)
	else $error("high entry sequence wrong");
property p_lo_seq;
	O_ACK && O_ISP |=> O_PUSH_PC ##1 !O_LOAD_PC ##1 O_LOAD_PC;
endproperty
a_lo_seq: assert property (p_lo_seq)
	else $error("low entry sequence wrong");
property p_vec;
	O_ACK |-> ##[2:3] O_LOAD_PC && O_VECTOR == `VIA_VEC_BASE + {O_ACK_IDX, 1'b0};
endproperty
a_vec: assert property (p_vec)
	else $error("vector wrong");
property p_trap;
	I_INSN_END && I_EXEC_BRK && !O_BUSY |=> O_ACK_SW && O_PUSH_PSW && !O_MAE
		##2 O_LOAD_PC && O_VECTOR == `VIA_TRAP_VEC;
endproperty
a_trap: assert property (p_trap)
	else $error("trap entry wrong");
property p_elig;
	O_ACK |-> elig_q[O_ACK_IDX] && $past(O_MAE);
endproperty
a_elig: assert property (p_elig)
	else $error("ineligible source taken");
property p_level;
	O_ACK && !$past(O_ISP) |-> !O_ISP;
endproperty
a_level: assert property (p_level)
	else $error("low request nested in high handler");
property p_order;
	O_ACK && O_ISP |-> hi_q == '0;
endproperty
a_order: assert property (p_order)
	else $error("low taken over high");
property p_hold;
	O_ACK |-> !$past(I_INSN_HOLD) && !$past(I_INSN_DIV) && !$past(I_EXEC_BRK);
endproperty
a_hold: assert property (p_hold)
	else $error("accept at a blocked boundary");
property p_ret;
	I_INSN_END && I_EXEC_RETURN_FROM_VECTORED && !I_EXEC_BRK && !O_BUSY
		|=> O_PSW == $past(I_POP_DATA);
endproperty
a_ret: assert property (p_ret)
	else $error("state word not restored");
property p_reset;
	$fell(I_SRST) |-> O_PSW == `VIA_PSW_RST && !O_BUSY;
endproperty
a_reset: assert property (p_reset)
	else $error("reset state wrong");

endmodule

bind via_core via_chk i_chk (
	.I_CLK, .I_SRST, .I_REQ_PEND, .I_REQ_MASK, .I_PRIO_SEL, .I_INSN_END,
	.I_INSN_HOLD, .I_INSN_DIV, .I_EXEC_BRK, .I_EXEC_RETURN_FROM_VECTORED, .I_POP_DATA,
	.O_PSW, .O_MAE, .O_ISP, .O_BUSY, .O_PUSH_PSW, .O_PUSH_PC, .O_PUSH_DATA,
	.O_LOAD_PC, .O_VECTOR, .O_ACK, .O_ACK_SW, .O_ACK_IDX
);

//--- verif/test_vectored_interrupt_acceptance.sv
// self-checking bench for the acceptance core
`timescale 1ns/1ps
`include "via_consts.svh"

module test_vectored_interrupt_acceptance
	import via_pkg::*;
;

// ****************************************************
// signals, design and partner
// ****************************************************
logic I_CLK = 1'b0;
logic I_SRST = 1'b1;
logic I_CE = 1'b1;
logic [15:0] I_PC = 16'h1234;
logic [`VIA_NSRC-1:0] I_REQ_MASK = '0;
logic [`VIA_NSRC-1:0] I_PRIO_SEL = '0;
logic [`VIA_NSRC-1:0] raise = '0;
logic go = 1'b0;
logic [7:0] op = '0;
logic [7:0] data = '0;
logic [`VIA_NSRC-1:0] I_REQ_PEND;
logic [7:0] op_q, pdata, O_PSW;
logic I_INSN_END, I_INSN_HOLD, O_MAE, O_ISP, O_BUSY, O_PUSH_PSW, O_PUSH_PC;
logic O_LOAD_PC, O_ACK, O_ACK_SW, O_SW_ACTIVE;
logic [15:0] O_PUSH_DATA, O_VECTOR, vec, pcw, psww;
logic [`VIA_IDXW-1:0] O_ACK_IDX;
int cyc, t0, lat, nload, checks, mismatches;

// 25 MHz cpu clock
always #20 I_CLK = ~I_CLK;

via_core i_dut (
	.I_CLK, .I_SRST, .I_CE, .I_REQ_PEND, .I_REQ_MASK, .I_PRIO_SEL,
	.I_INSN_END, .I_INSN_HOLD, .I_INSN_DIV(op_q[6]),
	.I_EXEC_EI(op_q[0]), .I_EXEC_DI(op_q[1]), .I_EXEC_BRK(op_q[5]),
	.I_EXEC_RETURN_FROM_VECTORED(op_q[2]), .I_EXEC_RETURN_FROM_TRAP(op_q[3]), .I_PSW_WE(op_q[4]),
	.I_PSW_WDATA(pdata), .I_POP_DATA(pdata), .I_PC, .O_PSW, .O_MAE,
	.O_ISP, .O_BUSY, .O_PUSH_PSW, .O_PUSH_PC, .O_PUSH_DATA, .O_LOAD_PC,
	.O_VECTOR, .O_ACK, .O_ACK_SW, .O_ACK_IDX, .O_SW_ACTIVE
);

via_cpu_model i_cpu (
	.i_clk(I_CLK), .i_srst(I_SRST), .i_busy(O_BUSY), .i_ack(O_ACK),
	.i_ack_idx(O_ACK_IDX), .i_raise(raise), .i_go(go), .i_op(op),
	.i_data(data), .o_pend(I_REQ_PEND), .o_end(I_INSN_END), .o_op(op_q),
	.o_hold(I_INSN_HOLD), .o_data(pdata)
);

// record pushes, vector loads and request latency
always @(posedge I_CLK) begin
	cyc <= cyc + 1;
	if (raise != '0) t0 <= cyc;
	if (O_PUSH_PSW) psww <= O_PUSH_DATA;
	if (O_PUSH_PC) pcw <= O_PUSH_DATA;
	if (O_LOAD_PC) begin
		nload <= nload + 1;
		vec <= O_VECTOR;
		lat <= cyc - t0 - 1;
	end
end

// ****************************************************
// tasks
// ****************************************************
task automatic end_sim();
	$display("checks %0d mismatches %0d", checks, mismatches);
	if (mismatches == 0 && checks > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask

task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
	checks++;
	if (g !== e) begin
		mismatches++;
		$display("mismatch %s expected %h seen %h", w, e, g);
	end
endtask

// wait for the entry sequence to finish, bounded
task automatic idle();
	int n;
	n = 0;
	while (O_BUSY !== 1'b0 && n < 50) begin
		@(posedge I_CLK);
		#1;
		n++;
	end
	if (n == 50) begin
		mismatches++;
		end_sim();
	end
endtask

// one instruction boundary: op bits ei,di,return_from_vectored,return_from_trap,we,brk,div
task automatic insn(input logic [7:0] o, input logic [7:0] d = 8'h00);
	idle();
	@(posedge I_CLK);
	go <= 1'b1;
	op <= o;
	data <= d;
	@(posedge I_CLK);
	go <= 1'b0;
	@(posedge I_CLK);
	#1;
endtask

task automatic req(input logic [`VIA_NSRC-1:0] m);
	@(posedge I_CLK);
	raise <= m;
	@(posedge I_CLK);
	raise <= '0;
endtask

// plain instructions until the wanted number of vector loads
task automatic wait_load(input int want);
	int n;
	n = 0;
	while (nload < want && n < 12) begin
		insn(8'h00);
		idle();
		n++;
	end
	chk("load count", want, nload);
endtask

// ****************************************************
// main sequence
// ****************************************************
initial begin
	repeat (16) @(posedge I_CLK);
	I_SRST <= 1'b0;
	@(posedge I_CLK);
	#1;
	chk("reset psw", 8'h02, O_PSW);
	chk("reset isp", 1'b1, O_ISP);
	I_REQ_MASK <= 32'h0000_0040;
	I_PRIO_SEL <= 32'h0000_0006;
	req(32'h0000_0060);
	repeat (4) insn(8'h00);
	insn(8'h01);
	insn(8'h02);
	repeat (4) insn(8'h00);
	chk("disabled", 0, nload);
	insn(8'h01);
	chk("busy after ei", 1'b0, O_BUSY);
	wait_load(1);
	chk("vec src5", 16'h000e, vec);
	chk("pushed psw", 16'h0082, psww);
	chk("pushed pc", 16'h1234, pcw);
	chk("psw in high", 8'h00, O_PSW);
	req(32'h0000_0204);
	insn(8'h10, 8'h80);
	wait_load(2);
	chk("high nests", 16'h0016, vec);
	insn(8'h04, 8'h80);
	chk("restored psw", 8'h80, O_PSW);
	repeat (6) insn(8'h00);
	chk("low held", 2, nload);
	insn(8'h04, 8'h82);
	chk("gap after return", 2, nload);
	wait_load(3);
	chk("vec src2", 16'h0008, vec);
	chk("low level", 1'b1, O_ISP);
	insn(8'h20);
	wait_load(4);
	chk("trap vec", 16'h003e, vec);
	chk("trap pushed psw", 16'h0002, psww);
	chk("trap active", 1'b1, O_SW_ACTIVE);
	insn(8'h08, 8'h82);
	chk("trap left", 1'b0, O_SW_ACTIVE);
	chk("trap restored", 8'h82, O_PSW);
	req(32'h0000_0002);
	wait_load(5);
	chk("low latency", 1'b1, lat >= 8 && lat <= 33);
	insn(8'h04, 8'h82);
	req(32'h0000_0001);
	wait_load(6);
	chk("high latency", 1'b1, lat >= 7 && lat <= 32);
	chk("vec src0", 16'h0004, vec);
	insn(8'h04, 8'h82);
	req(32'h0000_0010);
	repeat (8) insn(8'h40);
	chk("divide blocks", 6, nload);
	wait_load(7);
	chk("vec src4", 16'h000c, vec);
	chk("masked stays", 1'b1, I_REQ_PEND[6]);
	// enable low freezes the state word, so an enable instruction is lost
	I_CE <= 1'b0;
	insn(8'h01);
	chk("frozen enable", 1'b0, O_MAE);
	I_CE <= 1'b1;
	end_sim();
end

endmodule
